// ==== skp_skip_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "skp_defs.svh"

module skp_skip_unit
	import skp_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Instruction slot from the sequencer
	input wire logic insn_valid,
	input wire skp_op_t insn_op,
	// Interrupt control registers
	input wire logic [`SKP_CTRL_WIDTH-1:0] ext0_control_reg,
	input wire logic [`SKP_CTRL_WIDTH-1:0] ext1_control_reg,
	// External interrupt pins
	input wire logic ext_irq0_pin,
	input wire logic ext_irq1_pin,
	// Standby return flag control
	input wire logic standby_enter,
	input wire logic standby_flag_clear,
	// Answer to the sequencer
	output logic squash_active,
	output logic skip_taken,
	output logic test_done,
	output logic standby_return_flag
);

	////////////////////////////////////////////////////////////////////////

	skp_state_t state;
	skp_state_t next_state;
	logic flag_q;
	logic ext0_level_select;
	logic ext1_level_select;
	logic ext0_hit;
	logic ext1_hit;
	logic live_slot;
	logic cond_hit;
	logic next_skip;
	logic next_test_done;

	skp_standby_flag u_flag (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.flag_set(standby_enter),
		.flag_clear(standby_flag_clear),
		.flag(flag_q)
	);

	////////////////////////////////////////////////////////////////////////

	assign ext0_level_select = ext0_control_reg[`SKP_POL_BIT];
	assign ext1_level_select = ext1_control_reg[`SKP_POL_BIT];
	assign ext0_hit = skp_level_hit(ext_irq0_pin, ext0_level_select);
	assign ext1_hit = skp_level_hit(ext_irq1_pin, ext1_level_select);

	// A squashed skip instruction must not test, or skips would chain
	assign live_slot = insn_valid && (state == SKP_RUN);

	assign cond_hit = (insn_op == SKP_OP_EXT0) ? ext0_hit :
		(insn_op == SKP_OP_EXT1) ? ext1_hit :
		(insn_op == SKP_OP_STANDBY) ? flag_q : 1'b0;

	assign next_skip = live_slot && cond_hit;
	assign next_test_done = live_slot && (insn_op != SKP_OP_NONE);

	always_comb
	begin
		next_state = state;
		case (state)
			SKP_RUN:
			begin
				if (next_skip)
					next_state = SKP_DROP;
			end
			SKP_DROP:
			begin
				// Word is fetched and dropped, the counter still moves on
				if (insn_valid)
					next_state = SKP_RUN;
			end
			default:
			begin
				next_state = SKP_RUN;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state <= SKP_RUN;
			squash_active <= 1'b0;
			skip_taken <= 1'b0;
			test_done <= 1'b0;
			standby_return_flag <= `SKP_FLAG_RST;
		end
		else
		begin
			state <= next_state;
			squash_active <= (next_state == SKP_DROP);
			skip_taken <= next_skip;
			test_done <= next_test_done;
			standby_return_flag <= flag_q;
		end
	end

	////////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	property p_ext0_sel0;
		live_slot && insn_op == SKP_OP_EXT0 && !ext0_control_reg[2]
			|=> skip_taken == !$past(ext_irq0_pin);
	endproperty
	a_ext0_sel0: assert property (p_ext0_sel0) else $error("ext0 low-level skip wrong");

	property p_ext0_sel1;
		live_slot && insn_op == SKP_OP_EXT0 && ext0_control_reg[2]
			|=> skip_taken == $past(ext_irq0_pin);
	endproperty
	a_ext0_sel1: assert property (p_ext0_sel1) else $error("ext0 high-level skip wrong");

	property p_ext0_bit;
		live_slot && insn_op == SKP_OP_EXT0 && ext0_control_reg[2] == ext_irq0_pin
			|=> skip_taken && squash_active;
	endproperty
	a_ext0_bit: assert property (p_ext0_bit) else $error("ext0 select bit ignored");

	property p_ext1_sel0;
		live_slot && insn_op == SKP_OP_EXT1 && !ext1_control_reg[2]
			|=> skip_taken == !$past(ext_irq1_pin);
	endproperty
	a_ext1_sel0: assert property (p_ext1_sel0) else $error("ext1 low-level skip wrong");

	property p_ext1_sel1;
		live_slot && insn_op == SKP_OP_EXT1 && ext1_control_reg[2]
			|=> skip_taken == $past(ext_irq1_pin);
	endproperty
	a_ext1_sel1: assert property (p_ext1_sel1) else $error("ext1 high-level skip wrong");

	property p_ext1_bit;
		live_slot && insn_op == SKP_OP_EXT1 && ext1_control_reg[2] != ext_irq1_pin
			|=> !skip_taken && !squash_active;
	endproperty
	a_ext1_bit: assert property (p_ext1_bit) else $error("ext1 select bit ignored");

	property p_flag_skip;
		live_slot && insn_op == SKP_OP_STANDBY && !standby_enter && !standby_flag_clear
			|=> skip_taken == $past(flag_q) ##1 standby_return_flag == $past(flag_q, 2);
	endproperty
	a_flag_skip: assert property (p_flag_skip) else $error("standby flag skip wrong");

	property p_drop_one;
		squash_active && insn_valid |=> !squash_active && !skip_taken && !test_done;
	endproperty
	a_drop_one: assert property (p_drop_one) else $error("skipped word not dropped once");

	property p_one_cycle;
		next_skip |=> skip_taken && squash_active && test_done;
	endproperty
	a_one_cycle: assert property (p_one_cycle) else $error("skip test not one cycle");

	property p_test_pulse;
		live_slot && insn_op != SKP_OP_NONE
			|=> test_done;
	endproperty
	a_test_pulse: assert property (p_test_pulse) else $error("skip test not answered");

	property p_quiet_slot;
		(!live_slot || insn_op == SKP_OP_NONE)
			|=> !test_done && !skip_taken;
	endproperty
	a_quiet_slot: assert property (p_quiet_slot) else $error("answer without a live test");

	// Idle slots must not release the squash, or the skipped word would run
	property p_squash_hold;
		squash_active && !insn_valid
			|=> squash_active;
	endproperty
	a_squash_hold: assert property (p_squash_hold) else $error("squash lost on idle slot");

	property p_squash_cause;
		$rose(squash_active)
			|-> skip_taken;
	endproperty
	a_squash_cause: assert property (p_squash_cause) else $error("squash without a skip");

	property p_skip_is_test;
		skip_taken
			|-> test_done;
	endproperty
	a_skip_is_test: assert property (p_skip_is_test) else $error("skip without test done");

	property p_flag_hold;
		!standby_enter && !standby_flag_clear
			|=> flag_q == $past(flag_q);
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("standby flag moved alone");

	property p_flag_set_wins;
		standby_enter
			|=> flag_q;
	endproperty
	a_flag_set_wins: assert property (p_flag_set_wins) else $error("standby flag set lost");

	property p_flag_clear;
		standby_flag_clear && !standby_enter
			|=> !flag_q;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("standby flag not cleared");

	property p_flag_test;
		live_slot && insn_op == SKP_OP_STANDBY
			|=> skip_taken == $past(flag_q);
	endproperty
	a_flag_test: assert property (p_flag_test) else $error("standby skip ignores flag");

endmodule : skp_skip_unit
`default_nettype wire

// ==== skp_defs.svh ====
`ifndef SKP_DEFS_SVH
`define SKP_DEFS_SVH

`define SKP_CTRL_WIDTH 4
`define SKP_POL_BIT 2
`define SKP_FLAG_RST 1'b0
`define SKP_TEST_CYCLES 1

`endif

// ==== skp_pkg.sv ====
package skp_pkg;

	typedef enum logic [1:0] {
		SKP_OP_NONE,
		SKP_OP_EXT0,
		SKP_OP_EXT1,
		SKP_OP_STANDBY
	} skp_op_t;

	typedef enum logic {
		SKP_RUN,
		SKP_DROP
	} skp_state_t;

	// Level match shared by both pin tests
	function automatic logic skp_level_hit(input logic pin, input logic sel);
		skp_level_hit = sel ? pin : ~pin;
	endfunction : skp_level_hit

endpackage : skp_pkg

// ==== skp_standby_flag.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "skp_defs.svh"

module skp_standby_flag
	import skp_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Flag control
	input wire logic flag_set,
	input wire logic flag_clear,
	// Flag state
	output logic flag
);

	logic next_flag;

	// Set wins so a wake-up never gets lost under a clear
	assign next_flag = flag_set ? 1'b1 : (flag_clear ? 1'b0 : flag);

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			flag <= `SKP_FLAG_RST;
		else
			flag <= next_flag;
	end

endmodule : skp_standby_flag
`default_nettype wire

// ==== skp_top_note_placeholder.sv ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== skp_pin_src.sv ====
`timescale 1ns/1ps
`default_nettype none

module skp_pin_src (
	// Commanded levels
	input wire logic lvl0,
	input wire logic lvl1,
	// Pins toward the block
	output logic ext_irq0_pin,
	output logic ext_irq1_pin
);
	// Driven push-pull pins, no bounce, so the level in the test cycle is exact
	assign ext_irq0_pin = lvl0;
	assign ext_irq1_pin = lvl1;
endmodule : skp_pin_src

`default_nettype wire

// ==== skip_on_pin_level_and_flag_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

module skip_on_pin_level_and_flag_bench;
	import skp_pkg::*;
	logic mclk = 1'b0, sys_rst = 1'b1, insn_valid = 1'b0, lvl0 = 1'b0, lvl1 = 1'b0;
	logic st_en = 1'b0, st_clr = 1'b0, p0, p1, sq, sk, td, fl, s, p;
	logic [3:0] c0 = 4'h0, c1 = 4'h0, ctl;
	skp_op_t insn_op = SKP_OP_NONE;
	int n_errors = 0, num_checks = 0;
	always #4 mclk = ~mclk;
	skp_pin_src i_pins (.lvl0(lvl0), .lvl1(lvl1), .ext_irq0_pin(p0), .ext_irq1_pin(p1));
	skp_skip_unit i_dut (.mclk(mclk), .sys_rst(sys_rst), .insn_valid(insn_valid),
		.insn_op(insn_op), .ext0_control_reg(c0), .ext1_control_reg(c1), .ext_irq0_pin(p0),
		.ext_irq1_pin(p1), .standby_enter(st_en), .standby_flag_clear(st_clr),
		.squash_active(sq), .skip_taken(sk), .test_done(td), .standby_return_flag(fl));
	////////////////////////////////////////////////////////////////////////////////
	task check(input string what, input logic seen, input logic exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
		end
	endtask : check
	task tick;
		@(posedge mclk);
		#1;
	endtask : tick
	// Test, then a follow-up word; a skip must drop that word even if it is a skip op
	task run_op(input skp_op_t op, input skp_op_t nxt, input logic exp_skip);
		insn_valid = 1'b1;
		insn_op = op;
		tick;
		check("skip_taken", sk, exp_skip);
		check("test_done", td, 1'b1);
		check("squash_active", sq, exp_skip);
		insn_op = nxt;
		tick;
		insn_valid = 1'b0;
		check("dropped test_done", td, 1'b0);
		check("dropped skip", sk, 1'b0);
		check("squash released", sq, 1'b0);
		// Idle edge so the next call never re-raises valid in this step
		tick;
	endtask : run_op
	////////////////////////////////////////////////////////////////////////////////
	// Other control bits and the idle channel are set opposite to expose a wrong pick
	task pin_levels;
		for (int i = 0; i < 8; i++)
		begin
			s = i[0];
			p = i[1];
			ctl = s ? 4'h4 : 4'hb;
			lvl0 = p;
			lvl1 = p;
			c0 = i[2] ? ~ctl : ctl;
			c1 = i[2] ? ctl : ~ctl;
			run_op(i[2] ? SKP_OP_EXT1 : SKP_OP_EXT0, SKP_OP_NONE, s == p);
		end
		c0 = 4'h0;
		lvl0 = 1'b0;
		run_op(SKP_OP_EXT0, SKP_OP_EXT0, 1'b1);
	endtask : pin_levels
	task standby_flag;
		run_op(SKP_OP_STANDBY, SKP_OP_NONE, 1'b0);
		st_en = 1'b1;
		tick;
		st_en = 1'b0;
		tick;
		check("flag set", fl, 1'b1);
		run_op(SKP_OP_STANDBY, SKP_OP_NONE, 1'b1);
		check("flag kept", fl, 1'b1);
		st_clr = 1'b1;
		tick;
		st_clr = 1'b0;
		tick;
		check("flag cleared", fl, 1'b0);
		run_op(SKP_OP_STANDBY, SKP_OP_NONE, 1'b0);
		st_en = 1'b1;
		st_clr = 1'b1;
		tick;
		st_en = 1'b0;
		st_clr = 1'b0;
		tick;
		check("set wins", fl, 1'b1);
		run_op(SKP_OP_STANDBY, SKP_OP_NONE, 1'b1);
	endtask : standby_flag
	// Idle slot keeps the squash, then a reset in mid-run drops it and the flag
	task reset_mid;
		c0 = 4'h0;
		lvl0 = 1'b0;
		insn_valid = 1'b1;
		insn_op = SKP_OP_EXT0;
		tick;
		insn_valid = 1'b0;
		check("skip before idle", sk, 1'b1);
		tick;
		check("squash holds idle", sq, 1'b1);
		check("held skip", sk, 1'b0);
		check("held test_done", td, 1'b0);
		sys_rst = 1'b1;
		tick;
		check("reset squash", sq, 1'b0);
		check("reset flag", fl, 1'b0);
		sys_rst = 1'b0;
		run_op(SKP_OP_EXT0, SKP_OP_EXT0, 1'b1);
		run_op(SKP_OP_STANDBY, SKP_OP_NONE, 1'b0);
	endtask : reset_mid
	////////////////////////////////////////////////////////////////////////////////
	task close_out;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out
	initial
	begin
		repeat (16) @(posedge mclk);
		#1;
		sys_rst = 1'b0;
		check("idle squash", sq, 1'b0);
		check("idle skip", sk, 1'b0);
		check("idle test_done", td, 1'b0);
		check("idle flag", fl, 1'b0);
		pin_levels;
		standby_flag;
		reset_mid;
		close_out;
	end
	// Whole run is under a hundred cycles; this bound is generous
	initial
	begin
		#20000;
		n_errors++;
		close_out;
	end
endmodule : skip_on_pin_level_and_flag_bench

`default_nettype wire
